/* tmw_timer2_wave.sv */
// Timer-2 waveform generator: counter, compare units, pin override.
// Assumes one AHB-Lite master, word accesses, and ref_clk at 125 MHz.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps

module tmw_timer2_wave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pinAOut,
  output logic pinAOe_n,
  output logic pinBOut,
  output logic pinBOe_n
);

  tmw_pkg::tmw_ctrl_a_t ctrlA_ff;
  tmw_pkg::tmw_ctrl_b_t ctrlB_ff;
  logic [7:0] count_ff;
  logic [7:0] cmpBufA_ff;
  logic [7:0] cmpBufB_ff;
  logic [7:0] cmpA_ff;
  logic [7:0] cmpB_ff;
  logic upCount_ff;
  logic overflow_ff;
  logic blockMatch_ff;
  logic waveA_ff;
  logic waveB_ff;
  logic [3:0] port_ff;
  logic [9:0] prescale_ff;
  logic dphValid_ff;
  logic dphWrite_ff;
  logic [7:0] dphAddr_ff;
  logic rdReady_ff;
  logic [31:0] hrdata_ff;
  logic pinAOut_ff;
  logic pinBOut_ff;

  logic accept;
  logic wrEn;
  logic tick;
  logic [2:0] modeCode;
  tmw_pkg::tmw_class_t waveClass;
  logic [7:0] topVal;
  logic atTop;
  logic atBottom;
  logic matchA;
  logic matchB;
  logic ovfEvent;
  logic [7:0] nxt_count;
  logic nxt_up;
  logic holdPortA;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [9:0] div_mask(input logic [2:0] cs);
    unique case (cs)
      3'h1: div_mask = tmw_pkg::DIV1_MASK;
      3'h2: div_mask = tmw_pkg::DIV8_MASK;
      3'h3: div_mask = tmw_pkg::DIV32_MASK;
      3'h4: div_mask = tmw_pkg::DIV64_MASK;
      3'h5: div_mask = tmw_pkg::DIV128_MASK;
      3'h6: div_mask = tmw_pkg::DIV256_MASK;
      3'h7: div_mask = tmw_pkg::DIV1024_MASK;
      default: div_mask = tmw_pkg::DIV1_MASK;
    endcase
  endfunction

  // Next waveform level for one channel on a counter tick
  function automatic logic wave_next(
    input tmw_pkg::tmw_class_t cls,
    input logic [1:0] com,
    input logic toggleOk,
    input logic cur,
    input logic match,
    input logic top,
    input logic up,
    input logic cmpIsTop
  );
    logic inv;
    inv = (com == tmw_pkg::COM_SET);
    wave_next = cur;
    unique case (cls)
      tmw_pkg::CLS_NORMAL, tmw_pkg::CLS_CLEAR_ON_MATCH: begin
        if (match) begin
          unique case (com)
            tmw_pkg::COM_TOGGLE: wave_next = ~cur;
            tmw_pkg::COM_CLEAR: wave_next = 1'b0;
            tmw_pkg::COM_SET: wave_next = 1'b1;
            default: wave_next = cur;
          endcase
        end
      end
      tmw_pkg::CLS_FAST: begin
        if (com == tmw_pkg::COM_TOGGLE) begin
          if (toggleOk && match) begin
            wave_next = ~cur;
          end
        end else if (com[1]) begin
          if (top) begin
            wave_next = ~inv;
          end else if (match && !cmpIsTop) begin
            wave_next = inv;
          end
        end
      end
      tmw_pkg::CLS_PHASE: begin
        if (com == tmw_pkg::COM_TOGGLE) begin
          if (toggleOk && match) begin
            wave_next = ~cur;
          end
        end else if (com[1]) begin
          if (cmpIsTop) begin
            if (top) begin
              wave_next = ~inv;
            end
          end else if (match) begin
            wave_next = up ? inv : ~inv;
          end
        end
      end
    endcase
  endfunction

  // ****************************************************
  // Bus slave
  // ****************************************************
  // Reads take one wait state so read data always comes from a flop
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !(dphValid_ff && !dphWrite_ff && !rdReady_ff);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wrEn = dphValid_ff && dphWrite_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dphValid_ff <= 1'b0;
      dphWrite_ff <= 1'b0;
      dphAddr_ff <= 8'h00;
    end else if (accept) begin
      dphValid_ff <= 1'b1;
      dphWrite_ff <= hwrite;
      dphAddr_ff <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'h00;
    end else if (hreadyout) begin
      dphValid_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdReady_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else begin
      rdReady_ff <= dphValid_ff && !dphWrite_ff && !rdReady_ff;
      if (dphValid_ff && !dphWrite_ff && !rdReady_ff) begin
        unique case (dphAddr_ff)
          tmw_pkg::ADDR_CTRL_A:
            hrdata_ff <= {24'h000000, ctrlA_ff & tmw_pkg::CTRL_A_RD_MASK};
          tmw_pkg::ADDR_CTRL_B:
            hrdata_ff <= {24'h000000, ctrlB_ff & tmw_pkg::CTRL_B_RD_MASK};
          tmw_pkg::ADDR_COUNT: hrdata_ff <= {24'h000000, count_ff};
          tmw_pkg::ADDR_CMP_A: hrdata_ff <= {24'h000000, cmpBufA_ff};
          tmw_pkg::ADDR_CMP_B: hrdata_ff <= {24'h000000, cmpBufB_ff};
          tmw_pkg::ADDR_STATUS:
            hrdata_ff <= {28'h0000000, waveB_ff, waveA_ff, upCount_ff,
                          overflow_ff};
          tmw_pkg::ADDR_PORT: hrdata_ff <= {28'h0000000, port_ff};
          default: hrdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrlA_ff <= tmw_pkg::CTRL_A_RESET;
      ctrlB_ff <= tmw_pkg::CTRL_B_RESET;
      port_ff <= 4'h0;
      cmpBufA_ff <= 8'h00;
      cmpBufB_ff <= 8'h00;
    end else if (wrEn) begin
      unique case (dphAddr_ff)
        tmw_pkg::ADDR_CTRL_A: ctrlA_ff <= hwdata[7:0] & tmw_pkg::CTRL_A_RD_MASK;
        tmw_pkg::ADDR_CTRL_B: ctrlB_ff <= hwdata[7:0] & tmw_pkg::CTRL_B_RD_MASK;
        tmw_pkg::ADDR_CMP_A: cmpBufA_ff <= hwdata[7:0];
        tmw_pkg::ADDR_CMP_B: cmpBufB_ff <= hwdata[7:0];
        tmw_pkg::ADDR_PORT: port_ff <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // Mode decode and tick
  // ****************************************************
  assign modeCode = {ctrlB_ff.waveModeHighBit,
                     ctrlA_ff.waveModeLowBits};

  always_comb begin
    unique case (modeCode)
      3'h1, 3'h5: waveClass = tmw_pkg::CLS_PHASE;
      3'h3, 3'h7: waveClass = tmw_pkg::CLS_FAST;
      3'h2: waveClass = tmw_pkg::CLS_CLEAR_ON_MATCH;
      default: waveClass = tmw_pkg::CLS_NORMAL;
    endcase
  end

  // Reserved modes 4 and 6 run as normal counting
  assign topVal = (modeCode == 3'h2 || modeCode[2]) && modeCode != 3'h4
                  && modeCode != 3'h6 ? cmpA_ff : tmw_pkg::COUNT_MAX;
  assign atTop = count_ff == topVal;
  assign atBottom = count_ff == tmw_pkg::COUNT_BOTTOM;
  assign matchA = !blockMatch_ff && count_ff == cmpA_ff;
  assign matchB = !blockMatch_ff && count_ff == cmpB_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prescale_ff <= 10'h000;
    end else begin
      prescale_ff <= prescale_ff + 10'h001;
    end
  end

  assign tick = ctrlB_ff.countClockSelect != 3'h0 &&
                (prescale_ff & div_mask(ctrlB_ff.countClockSelect)) ==
                div_mask(ctrlB_ff.countClockSelect);

  // ****************************************************
  // Counting sequence
  // ****************************************************
  always_comb begin
    nxt_up = upCount_ff;
    nxt_count = count_ff + 8'h01;
    ovfEvent = 1'b0;
    unique case (waveClass)
      tmw_pkg::CLS_NORMAL: begin
        nxt_up = 1'b1;
        ovfEvent = count_ff == tmw_pkg::COUNT_MAX;
      end
      tmw_pkg::CLS_CLEAR_ON_MATCH: begin
        nxt_up = 1'b1;
        if (atTop) begin
          nxt_count = tmw_pkg::COUNT_BOTTOM;
        end
        ovfEvent = count_ff == tmw_pkg::COUNT_MAX;
      end
      tmw_pkg::CLS_FAST: begin
        nxt_up = 1'b1;
        if (atTop) begin
          nxt_count = tmw_pkg::COUNT_BOTTOM;
        end
        ovfEvent = modeCode[2] ? atTop
                   : count_ff == tmw_pkg::COUNT_MAX;
      end
      tmw_pkg::CLS_PHASE: begin
        if (upCount_ff && atTop) begin
          nxt_up = 1'b0;
          nxt_count = count_ff - 8'h01;
        end else if (!upCount_ff && atBottom) begin
          nxt_up = 1'b1;
          ovfEvent = 1'b1;
        end else if (!upCount_ff) begin
          nxt_count = count_ff - 8'h01;
        end
      end
    endcase
  end

  // A software write to the counter hides the next tick's match
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_ff <= tmw_pkg::COUNT_BOTTOM;
      upCount_ff <= 1'b1;
      blockMatch_ff <= 1'b0;
    end else if (wrEn && dphAddr_ff == tmw_pkg::ADDR_COUNT) begin
      count_ff <= hwdata[7:0];
      blockMatch_ff <= 1'b1;
    end else if (tick) begin
      count_ff <= nxt_count;
      upCount_ff <= nxt_up;
      blockMatch_ff <= 1'b0;
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overflow_ff <= 1'b0;
    end else if (tick && ovfEvent) begin
      overflow_ff <= 1'b1;
    end else if (wrEn && dphAddr_ff == tmw_pkg::ADDR_STATUS &&
                 hwdata[tmw_pkg::STAT_OVF_BIT]) begin
      overflow_ff <= 1'b0;
    end
  end

  // Double-buffered compare values in the PWM modes; copied every cycle otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmpA_ff <= 8'h00;
      cmpB_ff <= 8'h00;
    end else if (waveClass == tmw_pkg::CLS_NORMAL ||
                 waveClass == tmw_pkg::CLS_CLEAR_ON_MATCH ||
                 (tick && atTop && (waveClass == tmw_pkg::CLS_FAST ||
                  upCount_ff))) begin
      cmpA_ff <= cmpBufA_ff;
      cmpB_ff <= cmpBufB_ff;
    end
  end

  // ****************************************************
  // Waveform outputs and pins
  // ****************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waveA_ff <= 1'b0;
      waveB_ff <= 1'b0;
    end else if (tick) begin
      waveA_ff <= wave_next(waveClass, ctrlA_ff.compareAOutputMode,
                            modeCode[2], waveA_ff, matchA, atTop,
                            upCount_ff, cmpA_ff == topVal);
      waveB_ff <= wave_next(waveClass, ctrlA_ff.compareBOutputMode,
                            1'b0, waveB_ff, matchB, atTop,
                            upCount_ff, cmpB_ff == topVal);
    end
  end

  // PWM code 01 without the high bit leaves pin A to the port
  assign holdPortA = ctrlA_ff.compareAOutputMode == tmw_pkg::COM_TOGGLE &&
                     !modeCode[2] && (waveClass == tmw_pkg::CLS_FAST ||
                     waveClass == tmw_pkg::CLS_PHASE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinAOut_ff <= 1'b0;
      pinBOut_ff <= 1'b0;
    end else begin
      pinAOut_ff <= |ctrlA_ff.compareAOutputMode && !holdPortA ? waveA_ff
                    : port_ff[tmw_pkg::PORT_DAT_A_BIT];
      pinBOut_ff <= |ctrlA_ff.compareBOutputMode ? waveB_ff
                    : port_ff[tmw_pkg::PORT_DAT_B_BIT];
    end
  end

  assign pinAOut = pinAOut_ff;
  assign pinBOut = pinBOut_ff;
  assign pinAOe_n = !port_ff[tmw_pkg::PORT_DIR_A_BIT];
  assign pinBOe_n = !port_ff[tmw_pkg::PORT_DIR_B_BIT];

endmodule

/* tmw_pkg.sv */
// Shared constants and types of the timer-2 waveform output block.
// Assumes a single 125 MHz clock and word-wide AHB-Lite register access.
package tmw_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hB4;
  localparam logic [7:0] ADDR_COUNT = 8'hB8;
  localparam logic [7:0] ADDR_CMP_A = 8'hBC;
  localparam logic [7:0] ADDR_CMP_B = 8'hC0;
  localparam logic [7:0] ADDR_STATUS = 8'hC4;
  localparam logic [7:0] ADDR_PORT = 8'hC8;

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int CTRLB_HIGH_BIT = 3;
  localparam int STAT_OVF_BIT = 0;
  localparam int PORT_DIR_A_BIT = 0;
  localparam int PORT_DIR_B_BIT = 1;
  localparam int PORT_DAT_A_BIT = 2;
  localparam int PORT_DAT_B_BIT = 3;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_RD_MASK = 8'h0F;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // ****************************************************
  // Prescaler taps, as divide-minus-one masks
  // ****************************************************
  localparam logic [9:0] DIV1_MASK = 10'h000;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV32_MASK = 10'h01F;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV128_MASK = 10'h07F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  // ****************************************************
  // Compare output codes
  // ****************************************************
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef struct packed {
    logic [1:0] compareAOutputMode;
    logic [1:0] compareBOutputMode;
    logic [1:0] reserved;
    logic [1:0] waveModeLowBits;
  } tmw_ctrl_a_t;

  typedef struct packed {
    logic [3:0] unused;
    logic waveModeHighBit;
    logic [2:0] countClockSelect;
  } tmw_ctrl_b_t;

  typedef enum logic [1:0] {
    CLS_NORMAL,
    CLS_CLEAR_ON_MATCH,
    CLS_FAST,
    CLS_PHASE
  } tmw_class_t;

endpackage

/* tmw_pin_load.sv */
// External load on one waveform pin of the timer block.
// Assumes the pin level and active-low enable come straight from it.
`timescale 1ns/1ps
module tmw_pin_load (
  input wire logic ref_clk,
  input wire logic pinOut,
  input wire logic pinOe_n,
  output logic pad
);
  // ****************************************
  // Pad level
  // ****************************************
  logic last_ff;

  always_ff @(posedge ref_clk) begin
    if (!pinOe_n) begin
      last_ff <= pinOut;
    end
  end

  // Undriven pad shows the inverse, so a stale level never passes
  assign pad = pinOe_n ? ~last_ff : pinOut;
endmodule

/* tmw_timer2_wave_props.sv */
// Port-level checker of the timer-2 waveform block.
// Assumes hready is the block's own hreadyout.
`timescale 1ns/1ps
module tmw_wave_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic pinAOut,
  input wire logic pinAOe_n,
  input wire logic pinBOut,
  input wire logic pinBOe_n
);
  // ****************************************
  // Bus tracking and register shadows
  // ****************************************
  logic dpWr_ff, dpRd_ff;
  logic [7:0] dpAddr_ff, ctrlA_ff, port_ff;
  wire logic taken = hsel && htrans[1] && hready;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dpWr_ff <= 1'h0;
      dpRd_ff <= 1'h0;
      dpAddr_ff <= 8'h00;
    end else if (hready) begin
      dpWr_ff <= taken && hwrite;
      dpRd_ff <= taken && !hwrite;
      dpAddr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrlA_ff <= 8'h00;
      port_ff <= 8'h00;
    end else if (dpWr_ff && hready) begin
      if (dpAddr_ff == tmw_pkg::ADDR_CTRL_A) ctrlA_ff <= hwdata[7:0];
      if (dpAddr_ff == tmw_pkg::ADDR_PORT) port_ff <= hwdata[7:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  okay_resp_a: assert property (hresp == 1'h0)
    else $error("response not OKAY");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  resv_zero_a: assert property (
    dpRd_ff && hreadyout && dpAddr_ff == tmw_pkg::ADDR_CTRL_A
    |-> hrdata[31:8] == 24'h000000 && hrdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");
  dir_a_a: assert property (
    dpWr_ff && hready && dpAddr_ff == tmw_pkg::ADDR_PORT
    |=> pinAOe_n == !$past(hwdata[tmw_pkg::PORT_DIR_A_BIT]))
    else $error("pin A enable wrong");
  dir_b_a: assert property (
    dpWr_ff && hready && dpAddr_ff == tmw_pkg::ADDR_PORT
    |=> pinBOe_n == !$past(hwdata[tmw_pkg::PORT_DIR_B_BIT]))
    else $error("pin B enable wrong");
  pass_a_a: assert property (
    (ctrlA_ff[7:6] == 2'h0 && $stable(port_ff))[*2]
    |-> pinAOut == port_ff[tmw_pkg::PORT_DAT_A_BIT])
    else $error("pin A not port data");
  pass_b_a: assert property (
    (ctrlA_ff[5:4] == 2'h0 && $stable(port_ff))[*2]
    |-> pinBOut == port_ff[tmw_pkg::PORT_DAT_B_BIT])
    else $error("pin B not port data");
  reset_out_a: assert property ($fell(rst) |-> pinAOe_n && pinBOe_n &&
    !pinAOut && !pinBOut && hreadyout && hrdata == 32'h0)
    else $error("reset state wrong");
endmodule

bind tmw_timer2_wave tmw_wave_chk i_chk (.ref_clk(ref_clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .pinAOut(pinAOut), .pinAOe_n(pinAOe_n),
  .pinBOut(pinBOut), .pinBOe_n(pinBOe_n));

/* test_timer2_waveform_output_control.sv */
// Self-checking bench of the timer-2 waveform block.
// Assumes one AHB-Lite master here, hready tied to the block's hreadyout.
`timescale 1ns/1ps
module test_timer2_waveform_output_control;
  typedef struct packed {
    logic [7:0] ca, cb, ma, mb;
    logic [15:0] per, ea, eb;
  } tmw_case_t;
  // Control A, control B, compares, sample span, high cycles on A and B
  localparam tmw_case_t CASES [8] = '{
    {8'hB3, 8'h01, 8'h40, 8'hC0, 16'h0100, 16'h0041, 16'h003F},
    {8'hA3, 8'h01, 8'hFF, 8'h00, 16'h0100, 16'h0100, 16'h0001},
    {8'hB1, 8'h01, 8'h40, 8'h40, 16'h01FE, 16'h0080, 16'h017E},
    {8'hA1, 8'h01, 8'hFF, 8'h80, 16'h01FE, 16'h01FE, 16'h0100},
    {8'h63, 8'h09, 8'h3F, 8'h10, 16'h0080, 16'h0040, 16'h0022},
    {8'h61, 8'h09, 8'h3F, 8'h10, 16'h00FC, 16'h007E, 16'h0040},
    {8'h53, 8'h01, 8'h40, 8'h40, 16'h0100, 16'h0100, 16'h0000},
    {8'h52, 8'h01, 8'h1F, 8'h05, 16'h0040, 16'h0020, 16'h0020}};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, ha, hb;
  logic hreadyout, hresp, pinAOut, pinAOe_n, pinBOut, pinBOe_n, padA, padB;
  int nErrors = 0;
  int checksDone = 0;

  always #4 ref_clk = ~ref_clk;

  tmw_timer2_wave i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pinAOut(pinAOut),
    .pinAOe_n(pinAOe_n), .pinBOut(pinBOut), .pinBOe_n(pinBOe_n));
  tmw_pin_load i_loadA (.ref_clk(ref_clk), .pinOut(pinAOut),
    .pinOe_n(pinAOe_n), .pad(padA));
  tmw_pin_load i_loadB (.ref_clk(ref_clk), .pinOut(pinBOut),
    .pinOe_n(pinBOe_n), .pad(padB));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic give_verdict();
    if (nErrors == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits as long as it takes; the watchdog ends a real hang
  task automatic wait_rdy();
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) begin
      @(posedge ref_clk);
    end
  endtask

  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rw(1'h1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rw(1'h0, a, 32'h0);
    chk(q, e);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (30000) @(posedge ref_clk);
    nErrors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    rdchk(tmw_pkg::ADDR_CTRL_A, 32'h0);
    rdchk(tmw_pkg::ADDR_CTRL_B, 32'h0);
    wr(tmw_pkg::ADDR_CTRL_A, 32'hFF);
    rdchk(tmw_pkg::ADDR_CTRL_A, 32'hF3);
    rdchk(8'hF0, 32'h0);
    wr(tmw_pkg::ADDR_CTRL_A, 32'h0);
    wr(tmw_pkg::ADDR_PORT, 32'h7);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, padA}, 32'h1);
    chk({31'h0, padB}, 32'h0);
    wr(tmw_pkg::ADDR_COUNT, 32'h5);
    repeat (20) @(posedge ref_clk);
    rdchk(tmw_pkg::ADDR_COUNT, 32'h5);
    wr(tmw_pkg::ADDR_CMP_A, 32'h10);
    wr(tmw_pkg::ADDR_CMP_B, 32'h10);
    // Set, then clear, then toggle: each pass crosses the match once
    for (int i = 3; i > 0; i--) begin
      wr(tmw_pkg::ADDR_CTRL_B, 32'h0);
      wr(tmw_pkg::ADDR_COUNT, 32'h0E);
      wr(tmw_pkg::ADDR_CTRL_A, {24'h0, i[1:0], i[1:0], 4'h0});
      wr(tmw_pkg::ADDR_CTRL_B, 32'h1);
      repeat (12) @(posedge ref_clk);
      chk({31'h0, padA}, {31'h0, i != 2});
      chk({31'h0, padB}, {31'h0, i != 2});
    end
    for (int k = 0; k < 8; k++) begin
      wr(tmw_pkg::ADDR_CTRL_B, 32'h0);
      wr(tmw_pkg::ADDR_COUNT, 32'h0);
      wr(tmw_pkg::ADDR_CMP_A, {24'h0, CASES[k].ma});
      wr(tmw_pkg::ADDR_CMP_B, {24'h0, CASES[k].mb});
      wr(tmw_pkg::ADDR_CTRL_A, {24'h0, CASES[k].ca});
      wr(tmw_pkg::ADDR_CTRL_B, {24'h0, CASES[k].cb});
      repeat (1024) @(posedge ref_clk);
      ha = 32'h0;
      hb = 32'h0;
      repeat (CASES[k].per) begin
        @(posedge ref_clk);
        ha = ha + {31'h0, padA === 1'h1};
        hb = hb + {31'h0, padB === 1'h1};
      end
      chk(ha, {16'h0, CASES[k].ea});
      chk(hb, {16'h0, CASES[k].eb});
    end
    wr(tmw_pkg::ADDR_CTRL_B, 32'h0);
    wr(tmw_pkg::ADDR_CTRL_A, 32'h0);
    wr(tmw_pkg::ADDR_COUNT, 32'hFC);
    wr(tmw_pkg::ADDR_STATUS, 32'h1);
    wr(tmw_pkg::ADDR_CTRL_B, 32'h1);
    repeat (6) @(posedge ref_clk);
    wr(tmw_pkg::ADDR_CTRL_B, 32'h0);
    rw(1'h0, tmw_pkg::ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    wr(tmw_pkg::ADDR_STATUS, 32'h1);
    rw(1'h0, tmw_pkg::ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0);
    // 64 edges between start and stop hold exactly 64/8 or 64/32 ticks
    for (int s = 2; s < 4; s++) begin
      wr(tmw_pkg::ADDR_COUNT, 32'h0);
      wr(tmw_pkg::ADDR_CTRL_B, {30'h0, s[1:0]});
      repeat (62) @(posedge ref_clk);
      wr(tmw_pkg::ADDR_CTRL_B, 32'h0);
      rdchk(tmw_pkg::ADDR_COUNT, (s == 2) ? 32'h8 : 32'h2);
    end
    give_verdict();
  end
endmodule
